// File: rtl/hdca_pkg.sv
// package: register map, field layout and types of the halt debug block
package hdca_pkg;

  localparam logic [3:0]  HDCA_OFS_SELECTOR = 4'h0;
  localparam logic [3:0]  HDCA_OFS_DATA     = 4'h4;
  localparam logic [3:0]  HDCA_OFS_EMCR     = 4'h8;
  localparam logic [3:0]  HDCA_OFS_STATUS   = 4'hc;
  localparam logic [3:0]  HDCA_OFS_CONTROL  = 4'h0;

  localparam int          HDCA_SEL_DIR_BIT  = 16;
  localparam int          HDCA_EMCR_WATCH   = 24;
  localparam int          HDCA_EMCR_HFCATCH = 10;
  localparam int          HDCA_EMCR_RSCATCH = 0;
  localparam logic [31:0] HDCA_EMCR_MASK    = 32'h0100_0401;
  localparam logic [31:0] HDCA_EMCR_RESET   = 32'h0000_0000;

  localparam int          HDCA_ST_HALTED    = 0;
  localparam int          HDCA_ST_DONE      = 1;
  localparam int          HDCA_ST_DEBUGEN   = 2;
  localparam int          HDCA_ST_FAULT     = 3;

  localparam logic [4:0]  HDCA_IDX_RESUME   = 5'h0f;
  localparam logic [4:0]  HDCA_IDX_STATUS   = 5'h10;
  localparam logic [4:0]  HDCA_IDX_LAST_GPR = 5'h0c;

  // halt causes
  typedef enum logic [1:0] {
    HDCA_CAUSE_BKPT,
    HDCA_CAUSE_OTHER,
    HDCA_CAUSE_VCATCH
  } hdca_cause_t;

  // access to the core register file
  typedef struct packed {
    logic        req;
    logic        write;
    logic [4:0]  index;
    logic [31:0] wdata;
  } hdca_core_req_t;

  // debug event reported by the core
  typedef struct packed {
    logic        valid;
    logic        is_breakpoint;
    logic [31:0] bkpt_addr;
    logic [31:0] next_addr;
  } hdca_event_t;

endpackage

// File: rtl/hdca_xfer.sv
// transfer engine between the data register and the core register file
module hdca_xfer
  import hdca_pkg::*;
(
  input  wire logic         mclk_i,
  input  wire logic         reset_i,
  input  wire logic         start_i,
  input  wire logic         write_i,
  input  wire logic [4:0]   index_i,
  input  wire logic [31:0]  wdata_i,
  input  wire logic         core_ack_i,
  input  wire logic [31:0]  core_rdata_i,
  output hdca_core_req_t    core_req_o,
  output logic              done_o,
  output logic              rvalid_o,
  output logic [31:0]       rdata_o
);

  typedef enum logic [1:0] {ST_IDLE, ST_BUSY, ST_FIN} hdca_xst_t;

  hdca_xst_t      state;
  hdca_xst_t      next_state;
  hdca_core_req_t next_req;
  logic           next_rvalid;
  logic [31:0]    next_rdata;

  always_comb begin
    next_state  = state;
    next_req    = core_req_o;
    next_rvalid = 1'b0;
    next_rdata  = rdata_o;
    unique case (state)
      ST_IDLE: begin
        if (start_i) begin
          next_req.req   = 1'b1;
          next_req.write = write_i;
          next_req.index = index_i;
          // status writes pass every bit, no masking here
          next_req.wdata = wdata_i;
          next_state     = ST_BUSY;
        end
      end
      ST_BUSY: begin
        if (core_ack_i) begin
          next_req.req = 1'b0;
          if (!core_req_o.write) begin
            next_rdata  = core_rdata_i;
            next_rvalid = 1'b1;
          end
          next_state = ST_FIN;
        end
      end
      ST_FIN: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      state      <= ST_IDLE;
      core_req_o <= '0;
      rvalid_o   <= 1'b0;
      rdata_o    <= 32'h0000_0000;
    end else begin
      state      <= next_state;
      core_req_o <= next_req;
      rvalid_o   <= next_rvalid;
      rdata_o    <= next_rdata;
    end
  end

  // done only once the core has answered
  assign done_o = (state == ST_IDLE) && !start_i;

endmodule // hdca_xfer

// File: rtl/hdca_top.sv
// halting debug core access: selector, data, monitor control, resume address
////////////////////////////////////////////////////////////////////////////////
// How it works
// - breakpoint halt: resume address is the breakpointed instruction
// - other halts: resume address is next unexecuted sequential instruction
// - all earlier instructions retire before debug state is entered
// - resume address bit 0 reads zero, writes ignore it, state bit untouched
// - 32-bit data register holds transfer value, undefined while not ready
// - selector write clears transfer done; done set when move finishes
// - debugger status writes reach every status bit
// - a written resume address is where execution restarts
// - power-on clears all control bits; local reset clears watch enable
// - bit 24 enables watch unit; its reads are undefined while off
// - bit 10 enables halting trap on hard fault
// - bit 0 enables reset vector catch, local reset then halts
// - catch bits ignored while halting debug enable is zero
// - enabled catch halts at handler first instruction, enters debug
// - exception entry sets debug fault status bits
// - vector catch halts before any later instruction executes
// - late or derived exceptions may be taken first, delaying halt
// - selector bit 16 is direction, bits 4:0 register index
// - selector only accepted while in debug state
//
// Strobed register access and the placing of the registers were chosen for this implementation.
module hdca_top
  import hdca_pkg::*;
(
  input  wire logic         mclk_i,
  input  wire logic         reset_i,
  input  wire logic         local_reset_i,
  input  wire logic [3:0]   reg_addr_i,
  input  wire logic [31:0]  reg_wdata_i,
  input  wire logic         reg_write_i,
  input  wire logic         reg_read_i,
  output logic [31:0]       reg_rdata_o,
  input  wire logic         halting_debug_enable_i,
  input  wire logic         retire_empty_i,
  input  hdca_event_t       debug_event_i,
  input  wire logic         hard_fault_entry_i,
  input  wire logic         reset_handler_entry_i,
  input  wire logic [31:0]  handler_addr_i,
  input  wire logic         resume_req_i,
  input  wire logic         core_ack_i,
  input  wire logic [31:0]  core_rdata_i,
  output hdca_core_req_t    core_req_o,
  output logic              halted_o,
  output logic              stop_issue_o,
  output logic              resume_o,
  output logic [31:0]       resume_addr_o,
  output logic              watch_unit_enable_o,
  output logic [4:0]        debug_fault_status_o
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef enum logic [1:0] {DS_RUN, DS_DRAIN, DS_HALT} hdca_dst_t;

  hdca_dst_t    dstate;
  hdca_dst_t    next_dstate;
  logic [31:0]  transfer_temp_value;
  logic [31:0]  next_transfer_temp_value;
  logic [31:0]  exception_monitor_control;
  logic [31:0]  next_emcr;
  logic [31:0]  resume_addr;
  logic [31:0]  next_resume_addr;
  logic         next_halted;
  logic         next_stop;
  logic         next_resume;
  logic [31:0]  next_rdata;
  logic [4:0]   next_dfs;
  logic         pend_reset_catch;
  logic         next_pend_reset_catch;

  logic         sel_wr;
  logic         xfer_done;
  logic         xfer_rvalid;
  logic [31:0]  xfer_rdata;
  logic         catch_hf;
  logic         catch_rs;
  logic         resume_hit;
  logic         take_catch;
  logic         take_event;
  logic         wr_sel;
  logic         wr_data;
  logic         wr_emcr;
  logic         wr_status;
  logic [31:0]  status_word;

  function automatic logic [31:0] hdca_clr_bit0(input logic [31:0] a);
    return {a[31:1], 1'b0};
  endfunction

  // one write decode shared by every register
  function automatic logic hdca_wr_hit(input logic       wr,
                                       input logic [3:0] addr,
                                       input logic [3:0] ofs);
    return wr && (addr == ofs);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // decode

  assign wr_sel    = hdca_wr_hit(reg_write_i, reg_addr_i, HDCA_OFS_SELECTOR);
  assign wr_data   = hdca_wr_hit(reg_write_i, reg_addr_i, HDCA_OFS_DATA);
  assign wr_emcr   = hdca_wr_hit(reg_write_i, reg_addr_i, HDCA_OFS_EMCR);
  assign wr_status = hdca_wr_hit(reg_write_i, reg_addr_i, HDCA_OFS_STATUS);

  // selector writes outside debug state are dropped
  assign sel_wr = wr_sel && halted_o;

  // catch bits count only with halting debug enabled
  assign catch_hf = halting_debug_enable_i
                    && exception_monitor_control[HDCA_EMCR_HFCATCH]
                    && hard_fault_entry_i;
  assign catch_rs = halting_debug_enable_i
                    && pend_reset_catch
                    && reset_handler_entry_i;

  assign resume_hit = sel_wr && reg_wdata_i[HDCA_SEL_DIR_BIT]
                      && (reg_wdata_i[4:0] == HDCA_IDX_RESUME);

  hdca_xfer u_xfer (
    .mclk_i       (mclk_i),
    .reset_i      (reset_i),
    .start_i      (sel_wr),
    .write_i      (reg_wdata_i[HDCA_SEL_DIR_BIT]),
    .index_i      (reg_wdata_i[4:0]),
    .wdata_i      (transfer_temp_value),
    .core_ack_i   (core_ack_i),
    .core_rdata_i (core_rdata_i),
    .core_req_o   (core_req_o),
    .done_o       (xfer_done),
    .rvalid_o     (xfer_rvalid),
    .rdata_o      (xfer_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // halt decisions

  // a vector catch outranks a debug event seen in the same cycle
  assign take_catch = (dstate == DS_RUN) && (catch_hf || catch_rs);
  assign take_event = (dstate == DS_RUN) && !(catch_hf || catch_rs)
                      && debug_event_i.valid && halting_debug_enable_i;

  ////////////////////////////////////////////////////////////////////////////
  // data register

  always_comb begin
    next_transfer_temp_value = transfer_temp_value;
    if (wr_data) begin
      next_transfer_temp_value = reg_wdata_i;
    end
    if (xfer_rvalid) begin
      // resume address reads back with bit 0 clear
      next_transfer_temp_value = (core_req_o.index == HDCA_IDX_RESUME)
                                 ? resume_addr : xfer_rdata;
    end
  end

  // undefined phases keep the last value, no extra clearing logic
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      transfer_temp_value <= 32'h0000_0000;
    end else begin
      transfer_temp_value <= next_transfer_temp_value;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // monitor control

  always_comb begin
    next_emcr             = exception_monitor_control;
    next_pend_reset_catch = pend_reset_catch;
    if (wr_emcr) begin
      next_emcr = reg_wdata_i & HDCA_EMCR_MASK;
    end
    if (local_reset_i) begin
      next_emcr[HDCA_EMCR_WATCH] = 1'b0;
      // reset catch is armed when the local reset arrives
      next_pend_reset_catch =
        exception_monitor_control[HDCA_EMCR_RSCATCH];
    end else if (reset_handler_entry_i) begin
      next_pend_reset_catch = 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      exception_monitor_control <= HDCA_EMCR_RESET;
      pend_reset_catch          <= 1'b0;
    end else begin
      exception_monitor_control <= next_emcr;
      pend_reset_catch          <= next_pend_reset_catch;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // resume address

  always_comb begin
    next_resume_addr = resume_addr;
    if (take_catch) begin
      // halt on the handler first instruction
      next_resume_addr = hdca_clr_bit0(handler_addr_i);
    end else if (take_event) begin
      next_resume_addr = hdca_clr_bit0(debug_event_i.is_breakpoint
                         ? debug_event_i.bkpt_addr
                         : debug_event_i.next_addr);
    end else if (resume_hit) begin
      // written resume address kept halfword-clean (bit 0 cleared), state bit never touched
      next_resume_addr = hdca_clr_bit0(transfer_temp_value);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      resume_addr <= 32'h0000_0000;
    end else begin
      resume_addr <= next_resume_addr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fault status

  always_comb begin
    next_dfs = debug_fault_status_o;
    // write one to clear comes first so that a new event below wins
    if (wr_status) begin
      next_dfs = debug_fault_status_o & ~reg_wdata_i[8:4];
    end
    if (take_catch) begin
      next_dfs[4] = 1'b1;
    end else if (take_event) begin
      next_dfs[debug_event_i.is_breakpoint ? 1 : 2] = 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      debug_fault_status_o <= 5'h00;
    end else begin
      debug_fault_status_o <= next_dfs;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // halt sequencer

  always_comb begin
    next_dstate = dstate;
    next_halted = halted_o;
    next_stop   = stop_issue_o;
    next_resume = 1'b0;
    unique case (dstate)
      DS_RUN: begin
        // nothing further issues once a halt is decided
        if (take_catch || take_event) begin
          next_stop   = 1'b1;
          next_dstate = DS_DRAIN;
        end
        // a late or derived exception simply reaches entry later
        // and the catch above waits for it
      end
      DS_DRAIN: begin
        if (retire_empty_i) begin
          next_halted = 1'b1;
          next_dstate = DS_HALT;
        end
      end
      DS_HALT: begin
        // a transfer in flight finishes before the core runs again
        if (resume_req_i && xfer_done) begin
          next_halted = 1'b0;
          next_stop   = 1'b0;
          next_resume = 1'b1;
          next_dstate = DS_RUN;
        end
      end
      default: begin
        next_dstate = DS_RUN;
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      dstate       <= DS_RUN;
      halted_o     <= 1'b0;
      stop_issue_o <= 1'b0;
      resume_o     <= 1'b0;
    end else begin
      dstate       <= next_dstate;
      halted_o     <= next_halted;
      stop_issue_o <= next_stop;
      resume_o     <= next_resume;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port

  // status: fault bits, halting enable, transfer done, halted
  assign status_word = {23'h000000, debug_fault_status_o, 1'b0,
                        halting_debug_enable_i, xfer_done, halted_o};

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (reg_read_i) begin
      unique case (reg_addr_i)
        HDCA_OFS_DATA: begin
          next_rdata = transfer_temp_value;
        end
        HDCA_OFS_EMCR: begin
          next_rdata = exception_monitor_control;
        end
        HDCA_OFS_STATUS: begin
          next_rdata = status_word;
        end
        default: begin
          next_rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  // read data stand one cycle only and are zero otherwise
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else begin
      reg_rdata_o <= next_rdata;
    end
  end

  // resume address and watch enable straight from their flops
  assign resume_addr_o       = resume_addr;
  assign watch_unit_enable_o = exception_monitor_control[HDCA_EMCR_WATCH];

endmodule // hdca_top

// File: dv/hdca_core_model.sv
// partner: core register file answering transfer requests
module hdca_core_model
  import hdca_pkg::*;
(
  input  wire logic       mclk_i,
  input  wire logic       reset_i,
  input  wire logic [3:0] dly_i,
  input  hdca_core_req_t  req_i,
  output logic            ack_o,
  output logic [31:0]     rdata_o
);
  logic [31:0] regs [32];
  logic [31:0] last;
  logic [3:0]  cnt;
  //////////////////////////////////////////////////////////////////////////////
  always @(posedge mclk_i) begin
    ack_o <= 1'b0;
    // read data only valid with ack, never stale
    rdata_o <= ~last;
    if (reset_i) begin
      cnt <= 4'h0;
      last <= 32'h0;
    end else if (req_i.req && !ack_o) begin
      cnt <= cnt + 4'h1;
      if (cnt >= dly_i) begin
        ack_o <= 1'b1;
        cnt <= 4'h0;
        if (req_i.write)
          regs[req_i.index] <= req_i.wdata;
        else begin
          rdata_o <= regs[req_i.index];
          last <= regs[req_i.index];
        end
      end
    end
  end
endmodule // hdca_core_model

// File: dv/hdca_top_sva.sv
// checker: port-level properties of the halt debug block
module hdca_top_sva
  import hdca_pkg::*;
(
  input wire logic        mclk_i,
  input wire logic        reset_i,
  input wire logic        local_reset_i,
  input wire logic [3:0]  reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic        reg_write_i,
  input wire logic        halting_debug_enable_i,
  input wire logic        retire_empty_i,
  input hdca_event_t      debug_event_i,
  input wire logic        hard_fault_entry_i,
  input wire logic        core_ack_i,
  input hdca_core_req_t   core_req_o,
  input wire logic        halted_o,
  input wire logic        stop_issue_o,
  input wire logic        resume_o,
  input wire logic [31:0] resume_addr_o,
  input wire logic        watch_unit_enable_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  logic ev, sw;
  assign ev = debug_event_i.valid && !stop_issue_o && !halted_o
              && halting_debug_enable_i;
  assign sw = reg_write_i && reg_addr_i == HDCA_OFS_SELECTOR
              && !core_req_o.req;
  //////////////////////////////////////////////////////////////////////////////
  a_bit0_zero: assert property (resume_addr_o[0] == 1'b0)
    else $error("resume address bit 0 set");
  a_event_addr: assert property (ev |=> resume_addr_o ==
    {$past(debug_event_i.is_breakpoint ? debug_event_i.bkpt_addr[31:1]
      : debug_event_i.next_addr[31:1]), 1'b0})
    else $error("wrong resume address after event");
  a_event_stop: assert property (ev |=> stop_issue_o)
    else $error("issue not stopped after event");
  a_halt_retire: assert property ($rose(halted_o) |->
    $past(retire_empty_i) && $past(stop_issue_o))
    else $error("halted before retirement");
  a_watch_local: assert property (local_reset_i |=>
    !watch_unit_enable_o)
    else $error("watch enable kept over local reset");
  a_watch_write: assert property (reg_write_i && !local_reset_i &&
    reg_addr_i == HDCA_OFS_EMCR |=>
    watch_unit_enable_o == $past(reg_wdata_i[HDCA_EMCR_WATCH]))
    else $error("watch enable does not follow write");
  a_sel_refused: assert property (sw && !halted_o |=>
    !core_req_o.req)
    else $error("selector taken while running");
  a_sel_start: assert property (sw && halted_o |=> core_req_o.req &&
    core_req_o.write == $past(reg_wdata_i[HDCA_SEL_DIR_BIT]) &&
    core_req_o.index == $past(reg_wdata_i[4:0]))
    else $error("selector write did not start transfer");
  a_req_hold: assert property (core_req_o.req && !core_ack_i |=>
    core_req_o.req && $stable(core_req_o))
    else $error("core request dropped before ack");
  a_req_drop: assert property (core_req_o.req && core_ack_i |=>
    !core_req_o.req)
    else $error("core request held after ack");
  a_resume_pulse: assert property (resume_o |=> !resume_o)
    else $error("resume pulse too long");
  a_catch_off: assert property (hard_fault_entry_i && !ev &&
    !halting_debug_enable_i && !stop_issue_o && !halted_o |=>
    !stop_issue_o)
    else $error("catch taken with halting debug off");
endmodule // hdca_top_sva

bind hdca_top hdca_top_sva sva_u (.*);

// File: dv/hdca_top_bench.sv
// bench: drives the halt debug block against a behavioural model
module hdca_top_bench
  import hdca_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic           mclk_i, reset_i, local_reset_i, reg_write_i, reg_read_i;
  logic           halting_debug_enable_i, retire_empty_i, resume_req_i;
  logic           hard_fault_entry_i, reset_handler_entry_i, core_ack_i;
  logic           halted_o, stop_issue_o, resume_o, watch_unit_enable_o;
  logic [3:0]     reg_addr_i, dly;
  logic [4:0]     debug_fault_status_o;
  logic [31:0]    reg_wdata_i, reg_rdata_o, handler_addr_i, core_rdata_i;
  logic [31:0]    resume_addr_o, seed, v, a;
  logic [31:0]    exp_r [32];
  hdca_event_t    debug_event_i;
  hdca_core_req_t core_req_o;
  int             n_errors, samples_checked;
  hdca_top dut_u (.*);
  hdca_core_model core_u (.mclk_i(mclk_i), .reset_i(reset_i), .dly_i(dly),
    .req_i(core_req_o), .ack_o(core_ack_i), .rdata_o(core_rdata_i));
  always #4 mclk_i = ~mclk_i;
  //////////////////////////////////////////////////////////////////////////////
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task summarize();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e, input string m);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task tmo(input string m);
    n_errors++;
    $display("ERROR %0t wait for %s timed out", $time, m);
    summarize();
  endtask
  task wr(input logic [3:0] ad, input logic [31:0] d);
    reg_addr_i <= ad;
    reg_wdata_i <= d;
    reg_write_i <= 1'b1;
    @(posedge mclk_i);
    reg_write_i <= 1'b0;
    @(posedge mclk_i);
  endtask
  task rd(input logic [3:0] ad, output logic [31:0] d);
    reg_addr_i <= ad;
    reg_read_i <= 1'b1;
    @(posedge mclk_i);
    reg_read_i <= 1'b0;
    @(negedge mclk_i);
    d = reg_rdata_o;
    @(posedge mclk_i);
  endtask
  // waits for stop (0), halted (1) or resume (2)
  task wt(input int k);
    logic [2:0] f;
    for (int i = 0; i < 60; i++) begin
      @(negedge mclk_i);
      f = {resume_o, halted_o, stop_issue_o};
      if (f[k] === 1'b1) begin
        @(posedge mclk_i);
        return;
      end
    end
    tmo("halt state");
  endtask
  task xfer(input logic wrt, input logic [4:0] ix, input logic [31:0] d);
    logic [31:0] s;
    s = 32'h0;
    dly <= 4'(rnd() & 32'h7);
    if (wrt) wr(HDCA_OFS_DATA, d);
    wr(HDCA_OFS_SELECTOR, {15'h0, wrt, 11'h0, ix});
    for (int i = 0; i < 40 && s[HDCA_ST_DONE] !== 1'b1; i++)
      rd(HDCA_OFS_STATUS, s);
    if (s[HDCA_ST_DONE] !== 1'b1) tmo("transfer done");
    if (wrt) exp_r[ix] = d;
    else begin
      rd(HDCA_OFS_DATA, s);
      chk(s, exp_r[ix], "core read");
    end
  endtask
  task pulse(input int k);
    {reset_handler_entry_i, hard_fault_entry_i, local_reset_i} <= 3'h1 << k;
    @(posedge mclk_i);
    {reset_handler_entry_i, hard_fault_entry_i, local_reset_i} <= 3'h0;
  endtask
  task fire(input logic bk, input logic [31:0] ba, input logic [31:0] na);
    debug_event_i <= '{1'b1, bk, ba, na};
    @(posedge mclk_i);
    debug_event_i.valid <= 1'b0;
  endtask
  task halt(input logic [31:0] ea, input int fb);
    wt(0);
    chk(resume_addr_o, ea, "resume addr");
    chk(32'(debug_fault_status_o), 32'h1 << fb, "fault");
    chk(32'(halted_o), 32'h0, "early halt");
    retire_empty_i <= 1'b1;
    wt(1);
    wr(HDCA_OFS_STATUS, 32'h1f0);
  endtask
  task resume();
    resume_req_i <= 1'b1;
    retire_empty_i <= 1'b0;
    wt(2);
    resume_req_i <= 1'b0;
    @(posedge mclk_i);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    {mclk_i, local_reset_i, reg_write_i, reg_read_i, resume_req_i} = '0;
    {retire_empty_i, hard_fault_entry_i, reset_handler_entry_i} = '0;
    {reg_addr_i, dly, reg_wdata_i, handler_addr_i, debug_event_i} = '0;
    {n_errors, samples_checked} = '0;
    reset_i = 1'b1;
    halting_debug_enable_i = 1'b1;
    seed = 32'h383073fb;
    repeat (2) @(posedge mclk_i);
    reset_i <= 1'b0;
    rd(HDCA_OFS_EMCR, v);
    chk(v, HDCA_EMCR_RESET, "control reset");
    wr(HDCA_OFS_EMCR, 32'hffffffff);
    rd(HDCA_OFS_EMCR, v);
    chk(v, HDCA_EMCR_MASK, "control bits");
    chk(32'(watch_unit_enable_o), 32'h1, "watch on");
    pulse(0);
    rd(HDCA_OFS_EMCR, v);
    chk(v, HDCA_EMCR_MASK & 32'hfeffffff, "local reset");
    rd(4'h2, v);
    chk(v, 32'h0, "unmapped read");
    wr(HDCA_OFS_SELECTOR, 32'h0001_0000);
    chk(32'(core_req_o.req), 32'h0, "selector refused");
    $display("test control done");
    a = rnd() & 32'hfffffffe;
    handler_addr_i <= a;
    pulse(2);
    halt(a, 4);
    for (int i = 0; i <= 12; i++) xfer(1'b1, 5'(i), rnd());
    xfer(1'b1, HDCA_IDX_STATUS, 32'hffffffff);
    for (int i = 12; i >= 0; i--) xfer(1'b0, 5'(i), 32'h0);
    xfer(1'b0, HDCA_IDX_STATUS, 32'h0);
    a = rnd() | 32'h1;
    xfer(1'b1, HDCA_IDX_RESUME, a);
    chk(resume_addr_o, a & 32'hfffffffe, "written resume");
    exp_r[HDCA_IDX_RESUME] = a & 32'hfffffffe;
    xfer(1'b0, HDCA_IDX_RESUME, 32'h0);
    resume();
    $display("test transfer done");
    a = rnd();
    fire(1'b1, a, rnd());
    halt(a & 32'hfffffffe, 1);
    resume();
    a = rnd();
    fire(1'b0, rnd(), a);
    halt(a & 32'hfffffffe, 2);
    resume();
    a = rnd() & 32'hfffffffe;
    handler_addr_i <= a;
    pulse(1);
    halt(a, 4);
    resume();
    halting_debug_enable_i <= 1'b0;
    pulse(1);
    repeat (4) @(posedge mclk_i);
    chk(32'(stop_issue_o), 32'h0, "catch ignored");
    $display("test halt done");
    reset_i <= 1'b1;
    @(posedge mclk_i);
    reset_i <= 1'b0;
    rd(HDCA_OFS_EMCR, v);
    chk(v, 32'h0, "power-on clear");
    $display("test reset done");
    summarize();
  end
endmodule // hdca_top_bench
